// [rtl/remote_contact_ctrl.sv]
// What this block does
// RULE1: Selector value 2 takes command inputs from the control word.
// RULE2: Control-word bits 0..9 replace the ten digital input terminals.
// RULE3: Drive release needs control-word bit 0 and hardware release both set.
// RULE4: Input monitor shows emulated inputs only with release and bit 0 set.
// RULE5: Status bits 0..6 give 0x23, 0x27 or 0x08 for state; the code also gives 0x40 in idle before switch-on.
// RULE6: Status word fields: ready, on, released, error, ..., remote, reached, limit.
// RULE7: Fault enters error; acknowledge refused for 15 seconds after fault.
// RULE8: Latest fault cause held as readable error code.
// RULE9: Status bit 7 flags warning; causes readable in warnings value.
// RULE10: Remote bit set only with selector 2 and release; only then commands act.
// RULE11: Bit 10 set when actual within tolerance, or power-fail reached 0 Hz.
// RULE12: Bit 11 set while current, torque or overvoltage limit active.
// RULE13: Bit 15 on delayed critical warning; bit 7 follows bit 15.
// RULE14: Ramp source 1 internal, 2 line, 3 signed sum.
// RULE15: Line-only source limited to minimum frequency, sign kept from last nonzero.
// RULE16: Bus master writes line reference frequency parameter.
// RULE17: Internal reference, line reference and ramp output are readable.
// RULE18: In remote mode only hardware-source selections read terminals.
// RULE19: Operator sets selector 2 in every parameter set.
// RULE20: Master sends 16-bit control word, reads 16-bit status word.
// RULE21: Control-word bits 10..15 are ignored in remote mode.
`timescale 1ns/1ps
module remote_contact_ctrl
  import remote_contact_pkg::*;
#(
  parameter logic [BLOCK_CNT_W-1:0] BLOCK_CYCLES = BLOCK_CNT_W'(BLOCK_CYC)
) (
  // Clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  nrst_i,
  // Selectors, control word and frequency values
  input  wire logic [7:0]            ctrl_source_i,
  input  wire logic [15:0]           control_word_i,
  input  wire logic [1:0]            ramp_source_i,
  input  wire logic signed [FREQ_W-1:0] line_ref_freq_i,
  input  wire logic signed [FREQ_W-1:0] internal_ref_freq_i,
  input  wire logic [FREQ_W-1:0]     min_freq_i,
  input  wire logic signed [FREQ_W-1:0] actual_freq_i,
  input  wire logic [FREQ_W-1:0]     tolerance_i,
  // Terminal and drive-side levels
  input  wire logic [CW_INPUTS-1:0]  terminal_inputs_i,
  input  wire logic                  hw_release_i,
  input  wire logic                  switched_on_i,
  input  wire logic                  fault_i,
  input  wire logic [7:0]            fault_code_i,
  input  wire logic                  fault_ack_i,
  input  wire logic [15:0]           warnings_i,
  input  wire logic                  critical_warning_flag_i,
  input  wire logic                  power_fail_zero_i,
  input  wire logic                  current_limit_i,
  input  wire logic                  torque_limit_i,
  input  wire logic                  overvoltage_ctrl_i,
  // Registered outputs
  output logic [CW_INPUTS-1:0]       command_inputs_o,
  output logic [CW_INPUTS-1:0]       input_monitor_o,
  output logic [CW_INPUTS-1:0]       hw_source_inputs_o,
  output logic                       drive_release_o,
  output logic [15:0]                drive_state_flags_o,
  output logic [7:0]                 current_error_o,
  output logic [15:0]                warnings_o,
  output logic signed [FREQ_W-1:0]   internal_ref_o,
  output logic signed [FREQ_W-1:0]   bus_ref_o,
  output logic signed [FREQ_W-1:0]   ramp_ref_o
);

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [2:0] {
    DRV_IDLE  = 3'b001,
    DRV_RUN   = 3'b010,
    DRV_FAULT = 3'b100
  } drv_state_t;

  typedef struct packed {
    drv_state_t               drv;
    logic                     line_neg;
    logic [CW_INPUTS-1:0]     cmd;
    logic [CW_INPUTS-1:0]     mon;
    logic [CW_INPUTS-1:0]     hwsrc;
    logic                     release_q;
    logic [15:0]              status;
    logic [7:0]               err;
    logic [15:0]              warn;
    logic signed [FREQ_W-1:0] intref;
    logic signed [FREQ_W-1:0] busref;
    logic signed [FREQ_W-1:0] ramp;
  } ctrl_state_t;

  ctrl_state_t st;
  ctrl_state_t next_st;
  logic        block_busy;
  logic        fault_start;

  // ****************************************
  // Helper functions
  // ****************************************
  // Absolute value, used for both tolerance and minimum checks
  function automatic logic [FREQ_W-1:0] mag(input logic signed [FREQ_W-1:0] v);
    mag = v[FREQ_W-1] ? FREQ_W'(-v) : FREQ_W'(v);
  endfunction

  // Selector decode, shared by command, monitor and remote flag
  function automatic logic is_remote_sel(input logic [7:0] sel);
    is_remote_sel = (sel == CTRL_SRC_REMOTE);
  endfunction

  // ****************************************
  // Blocking timer
  // ****************************************
  // Fault start pulses only on entry, so a held fault input keeps one window
  assign fault_start = fault_i && (st.drv != DRV_FAULT);

  // RULE7: fault blocking window
  fault_block_timer #(
    .BLOCK_CYCLES (BLOCK_CYCLES)
  ) u_block (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .start_i    (fault_start),
    .busy_o     (block_busy)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic                     remote;
    logic                     rel;
    logic [CW_INPUTS-1:0]     emu;
    logic signed [FREQ_W:0]   sum;
    logic signed [FREQ_W-1:0] line_lim;
    logic signed [FREQ_W-1:0] diff;
    logic [6:0]               code;
    remote   = 1'b0;
    rel      = 1'b0;
    emu      = '0;
    sum      = '0;
    line_lim = '0;
    diff     = '0;
    code     = CODE_IDLE;
    next_st  = st;

    // ****************************************
    // Command source
    // ****************************************
    // RULE1: remote-contact source select
    // RULE10: commands act only with release present
    remote = is_remote_sel(ctrl_source_i) && hw_release_i;

    // RULE2: bits 0..9 emulate the terminals
    // RULE21: upper bits dropped
    emu = control_word_i[CW_INPUTS-1:0];
    if (is_remote_sel(ctrl_source_i)) begin
      // Without the hardware release no emulated input is passed on
      next_st.cmd = remote ? emu : '0;
    end else begin
      // Terminal mode passes the pins through
      next_st.cmd = terminal_inputs_i;
    end

    // RULE18: hardware-source selections always see terminals
    next_st.hwsrc = terminal_inputs_i;

    // ****************************************
    // Release and monitor
    // ****************************************
    // RULE3: software alone never releases
    rel = hw_release_i && next_st.cmd[0] && (st.drv != DRV_FAULT);
    next_st.release_q = rel && (st.drv == DRV_RUN);

    // RULE4: monitor gated by release and bit 0
    if (is_remote_sel(ctrl_source_i)) begin
      // Monitor reads clear unless both release conditions hold
      next_st.mon = (hw_release_i && control_word_i[0]) ? emu : '0;
    end else begin
      next_st.mon = terminal_inputs_i;
    end

    // ****************************************
    // Drive sequence
    // ****************************************
    // RULE7: fault entry and blocked acknowledge
    case (st.drv)
      DRV_IDLE: begin
        // Fault has priority over a start
        if (fault_i) begin
          next_st.drv = DRV_FAULT;
        end else if (switched_on_i && rel) begin
          next_st.drv = DRV_RUN;
        end
      end
      DRV_RUN: begin
        // Losing either release condition drops back to idle
        if (fault_i) begin
          next_st.drv = DRV_FAULT;
        end else if (!switched_on_i || !rel) begin
          next_st.drv = DRV_IDLE;
        end
      end
      DRV_FAULT: begin
        // Acknowledge waits for the blocking window and a quiet fault line
        if (fault_ack_i && !block_busy && !fault_i) begin
          next_st.drv = DRV_IDLE;
        end
      end
      default: begin
        next_st.drv = DRV_IDLE;
      end
    endcase

    // ****************************************
    // Fault record and warnings
    // ****************************************
    // RULE8: keep the latest fault cause
    if (fault_start) begin
      next_st.err = fault_code_i;
    end

    // RULE9: warning causes readable
    next_st.warn = warnings_i;

    // ****************************************
    // Ramp source
    // ****************************************
    // RULE14: ramp source selection
    // RULE15: line-only value limited to minimum magnitude
    // Sign memory follows only nonzero line values
    if (line_ref_freq_i != '0) begin
      next_st.line_neg = line_ref_freq_i[FREQ_W-1];
    end
    // Small line values are raised to the minimum magnitude
    if (mag(line_ref_freq_i) < min_freq_i) begin
      line_lim = next_st.line_neg ? FREQ_W'(-$signed({1'b0, min_freq_i[FREQ_W-2:0]}))
                                  : $signed({1'b0, min_freq_i[FREQ_W-2:0]});
    end else begin
      line_lim = line_ref_freq_i;
    end
    // Sign-extended sum keeps the carry out of the signed range
    sum = {internal_ref_freq_i[FREQ_W-1], internal_ref_freq_i}
        + {line_ref_freq_i[FREQ_W-1], line_ref_freq_i};
    case (ramp_source_i)
      RAMP_INTERNAL: begin
        next_st.ramp = internal_ref_freq_i;
      end
      RAMP_LINE: begin
        // Line-only value already limited to the minimum
        next_st.ramp = line_lim;
      end
      RAMP_SUM: begin
        // Wraps to the output width; the master keeps the sum in range
        next_st.ramp = sum[FREQ_W-1:0];
      end
      default: begin
        // Unused code 0 falls back to the internal channel
        next_st.ramp = internal_ref_freq_i;
      end
    endcase

    // ****************************************
    // Readbacks
    // ****************************************
    // RULE17: readable reference values
    next_st.intref = internal_ref_freq_i;
    next_st.busref = line_ref_freq_i;

    // ****************************************
    // Status word
    // ****************************************
    // RULE5: state code in bits 0..6
    // Code follows the registered state, so it trails a transition by one cycle
    case (st.drv)
      DRV_RUN: begin
        code = CODE_OPREL;
      end
      DRV_FAULT: begin
        code = CODE_ERROR;
      end
      DRV_IDLE: begin
        // Lock-out code until the drive is switched on
        code = switched_on_i ? CODE_SWON : CODE_IDLE;
      end
      default: begin
        code = CODE_IDLE;
      end
    endcase

    // RULE6: status word assembly
    // Bits 4, 8 and 12..14 stay clear, as does bit 5 in error
    next_st.status = STATUS_RST;
    next_st.status[ST_LOCKOUT:ST_READY] = code;

    // RULE13: critical warning forces bit 7
    next_st.status[ST_WARN2] = critical_warning_flag_i;
    next_st.status[ST_WARN]  = (warnings_i != '0) || critical_warning_flag_i;

    // RULE10: remote flag
    next_st.status[ST_REMOTE] = remote;

    // RULE11: reference reached
    // Compared against the ramp output, not the raw line value
    diff = actual_freq_i - next_st.ramp;
    next_st.status[ST_REFREACH] = (mag(diff) <= tolerance_i) || power_fail_zero_i;

    // RULE12: any internal limit
    next_st.status[ST_LIMIT] = current_limit_i || torque_limit_i || overvoltage_ctrl_i;
  end

  // ****************************************
  // Registers
  // ****************************************
  // Whole state cleared first, then fields with a meaningful reset value
  // Sign defaults positive after power-up
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st          <= '0;
      st.drv      <= DRV_IDLE;
      st.status   <= STATUS_RST;
      st.err      <= ERRCODE_RST;
      st.line_neg <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs, all registered
  // ****************************************
  // Plain wires from the state register, no logic after the flops
  assign command_inputs_o    = st.cmd;
  assign input_monitor_o     = st.mon;
  assign hw_source_inputs_o  = st.hwsrc;
  assign drive_release_o     = st.release_q;
  assign drive_state_flags_o = st.status;
  assign current_error_o     = st.err;
  assign warnings_o          = st.warn;
  assign internal_ref_o      = st.intref;
  assign bus_ref_o           = st.busref;
  assign ramp_ref_o          = st.ramp;

endmodule

// [rtl/remote_contact_pkg.sv]
package remote_contact_pkg;

  // ****************************************
  // Selector values
  // ****************************************
  localparam logic [7:0] CTRL_SRC_REMOTE = 8'h02;
  localparam logic [1:0] RAMP_INTERNAL   = 2'h1;
  localparam logic [1:0] RAMP_LINE       = 2'h2;
  localparam logic [1:0] RAMP_SUM        = 2'h3;

  // ****************************************
  // Status word field positions
  // ****************************************
  localparam int ST_READY    = 0;
  localparam int ST_SWON     = 1;
  localparam int ST_OPREL    = 2;
  localparam int ST_ERROR    = 3;
  localparam int ST_VOLTDIS  = 4;
  localparam int ST_QSTOP    = 5;
  localparam int ST_LOCKOUT  = 6;
  localparam int ST_WARN     = 7;
  localparam int ST_REMOTE   = 9;
  localparam int ST_REFREACH = 10;
  localparam int ST_LIMIT    = 11;
  localparam int ST_WARN2    = 15;

  // ****************************************
  // State codes in status bits 0..6
  // ****************************************
  localparam logic [6:0] CODE_SWON  = 7'h23;
  localparam logic [6:0] CODE_OPREL = 7'h27;
  localparam logic [6:0] CODE_ERROR = 7'h08;
  localparam logic [6:0] CODE_IDLE  = 7'h40;

  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int CW_INPUTS = 10;
  localparam int FREQ_W    = 18;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [7:0]  ERRCODE_RST = 8'h00;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ         = 20000000;
  localparam int BLOCK_TIME_S   = 15;
  localparam longint BLOCK_CYC  = longint'(BLOCK_TIME_S) * longint'(CLK_HZ);
  localparam int BLOCK_CNT_W    = 29;

endpackage

// [rtl/fault_block_timer.sv]
`timescale 1ns/1ps
module fault_block_timer
  import remote_contact_pkg::*;
#(
  parameter logic [BLOCK_CNT_W-1:0] BLOCK_CYCLES = BLOCK_CNT_W'(BLOCK_CYC)
) (
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  input  wire logic start_i,
  output logic      busy_o
);

  typedef struct packed {
    logic [BLOCK_CNT_W-1:0] cnt;
    logic                   busy;
  } timer_state_t;

  timer_state_t st;
  timer_state_t next_st;

  // Restart on every fault entry, count down to expiry
  always_comb begin
    next_st = st;
    if (start_i) begin
      next_st.cnt  = BLOCK_CYCLES;
      next_st.busy = 1'b1;
    end else if (st.busy) begin
      if (st.cnt <= BLOCK_CNT_W'(1)) begin
        next_st.cnt  = '0;
        next_st.busy = 1'b0;
      end else begin
        next_st.cnt = st.cnt - BLOCK_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy_o = st.busy;

endmodule

// [sim/remote_contact_ctrl_assertions.sv]
`timescale 1ns/1ps
module remote_contact_ctrl_checker
  import remote_contact_pkg::*;
(
  input wire logic                 core_clk_i,
  input wire logic                 nrst_i,
  input wire logic [7:0]           ctrl_source_i,
  input wire logic [15:0]          control_word_i,
  input wire logic                 hw_release_i,
  input wire logic                 fault_i,
  input wire logic [7:0]           fault_code_i,
  input wire logic                 critical_warning_flag_i,
  input wire logic                 current_limit_i,
  input wire logic                 torque_limit_i,
  input wire logic                 overvoltage_ctrl_i,
  input wire logic [CW_INPUTS-1:0] command_inputs_o,
  input wire logic [CW_INPUTS-1:0] input_monitor_o,
  input wire logic                 drive_release_o,
  input wire logic [15:0]          drive_state_flags_o,
  input wire logic [7:0]           current_error_o
);
  // One domain, so clock and reset are given once
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_cmd_copy;
    ctrl_source_i == CTRL_SRC_REMOTE && hw_release_i |=> command_inputs_o == $past(control_word_i[9:0]);
  endproperty
  a_cmd_copy: assert property (p_cmd_copy) else $error("command inputs wrong");
  property p_monitor_clear;
    ctrl_source_i == CTRL_SRC_REMOTE && !(hw_release_i && control_word_i[0]) |=> input_monitor_o == '0;
  endproperty
  a_monitor_clear: assert property (p_monitor_clear) else $error("monitor not clear");
  property p_release_needs_both;
    drive_release_o |-> $past(hw_release_i) && $past(control_word_i[0]);
  endproperty
  a_release_needs_both: assert property (p_release_needs_both) else $error("release without cause");
  property p_remote_bit;
    1'b1 |=> drive_state_flags_o[ST_REMOTE] == $past(ctrl_source_i == CTRL_SRC_REMOTE && hw_release_i);
  endproperty
  a_remote_bit: assert property (p_remote_bit) else $error("remote bit wrong");
  property p_limit_bit;
    1'b1 |=> drive_state_flags_o[ST_LIMIT] == $past(current_limit_i | torque_limit_i | overvoltage_ctrl_i);
  endproperty
  a_limit_bit: assert property (p_limit_bit) else $error("limit bit wrong");
  property p_warn2_bits;
    critical_warning_flag_i |=> drive_state_flags_o[ST_WARN2] && drive_state_flags_o[ST_WARN];
  endproperty
  a_warn2_bits: assert property (p_warn2_bits) else $error("warning bits wrong");
  property p_fault_entry;
    $rose(fault_i) && !drive_state_flags_o[ST_ERROR] |=>
      current_error_o == $past(fault_code_i) ##1 drive_state_flags_o[6:0] == CODE_ERROR;
  endproperty
  a_fault_entry: assert property (p_fault_entry) else $error("fault entry wrong");
  property p_error_blocked;
    $rose(drive_state_flags_o[ST_ERROR]) |-> drive_state_flags_o[ST_ERROR] [*8];
  endproperty
  a_error_blocked: assert property (p_error_blocked) else $error("error left early");
endmodule

bind remote_contact_ctrl remote_contact_ctrl_checker checker_i (.*);

// [sim/line_master_model.sv]
`timescale 1ns/1ps
module line_master_model
  import remote_contact_pkg::*;
(
  input  wire logic                core_clk_i,
  output logic [7:0]               ctrl_source_o,
  output logic [15:0]              control_word_o,
  output logic signed [FREQ_W-1:0] line_ref_freq_o
);
  // Master idles in terminal mode with empty words
  initial begin
    ctrl_source_o = 8'h00;
    control_word_o = 16'h0000;
    line_ref_freq_o = 18'h00000;
  end
  task automatic put_word(input logic [7:0] src, input logic [15:0] cw);
    @(posedge core_clk_i);
    ctrl_source_o <= src;
    control_word_o <= cw;
  endtask
  task automatic put_line(input logic [FREQ_W-1:0] f);
    @(posedge core_clk_i);
    line_ref_freq_o <= f;
  endtask
endmodule

// [sim/remote_contact_ctrl_tb_top.sv]
`timescale 1ns/1ps
module remote_contact_ctrl_tb_top
  import remote_contact_pkg::*;
();
  logic                      core_clk_i, nrst_i, hw_release_i, switched_on_i, fault_i, fault_ack_i;
  logic                      critical_warning_flag_i, power_fail_zero_i, drive_release_o;
  logic                      current_limit_i, torque_limit_i, overvoltage_ctrl_i;
  logic [1:0]                ramp_source_i;
  logic [7:0]                ctrl_source_i, fault_code_i, current_error_o;
  logic [15:0]               control_word_i, warnings_i, warnings_o, drive_state_flags_o;
  logic [CW_INPUTS-1:0]      terminal_inputs_i, command_inputs_o, input_monitor_o, hw_source_inputs_o;
  logic [FREQ_W-1:0]         min_freq_i, tolerance_i;
  logic signed [FREQ_W-1:0]  line_ref_freq_i, internal_ref_freq_i, actual_freq_i;
  logic signed [FREQ_W-1:0]  internal_ref_o, bus_ref_o, ramp_ref_o;
  int                        miscompares, check_count;

  // Short blocking count keeps the fault run brief
  remote_contact_ctrl #(.BLOCK_CYCLES(29'h14)) DUT (.*);
  line_master_model master (.core_clk_i(core_clk_i), .ctrl_source_o(ctrl_source_i), .control_word_o(control_word_i),
                            .line_ref_freq_o(line_ref_freq_i));

  // Clock of 50 ns
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  task automatic tick;
    @(posedge core_clk_i);
  endtask
  // Checks land on falling edges, clear of updates
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  task automatic chk(input logic [17:0] g, input logic [17:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic conclude;
    if (miscompares == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Ramp sources, min limit and sign memory
  task automatic s_ramp;
    tick();
    min_freq_i <= 18'h00032;
    internal_ref_freq_i <= 18'h00064;
    ramp_source_i <= RAMP_LINE;
    cyc(2);
    chk(ramp_ref_o, 18'h00032);
    master.put_line(18'h3FFE2);
    cyc(2);
    chk(ramp_ref_o, 18'h3FFCE);
    master.put_line(18'h00000);
    cyc(2);
    chk(ramp_ref_o, 18'h3FFCE);
    master.put_line(18'h3FFE2);
    tick();
    ramp_source_i <= RAMP_SUM;
    actual_freq_i <= 18'h00046;
    cyc(2);
    chk(ramp_ref_o, 18'h00046);
    chk(bus_ref_o, 18'h3FFE2);
    chk(internal_ref_o, 18'h00064);
    chk(drive_state_flags_o[ST_REFREACH], 1'b1);
    tick();
    ramp_source_i <= RAMP_INTERNAL;
    cyc(2);
    chk(ramp_ref_o, 18'h00064);
  endtask

  // Warning, reached and limit flags
  task automatic s_flags;
    tick();
    warnings_i <= 16'h0104;
    cyc(2);
    chk(warnings_o, 16'h0104);
    chk({drive_state_flags_o[ST_WARN2], drive_state_flags_o[ST_WARN]}, 2'h1);
    chk(drive_state_flags_o[ST_REFREACH], 1'b0);
    tick();
    tolerance_i <= 18'h0001E;
    cyc(2);
    chk(drive_state_flags_o[ST_REFREACH], 1'b1);
    tick();
    warnings_i <= 16'h0000;
    critical_warning_flag_i <= 1'b1;
    power_fail_zero_i <= 1'b1;
    cyc(2);
    chk({drive_state_flags_o[ST_WARN2], drive_state_flags_o[ST_WARN]}, 2'h3);
    chk(drive_state_flags_o[ST_REFREACH], 1'b1);
    for (int i = 0; i < 4; i++) begin
      tick();
      {current_limit_i, torque_limit_i, overvoltage_ctrl_i} <= 3'h1 << i;
      cyc(2);
      chk(drive_state_flags_o[ST_LIMIT], i < 3);
    end
    chk({drive_state_flags_o[14:12], drive_state_flags_o[8], drive_state_flags_o[4]}, 5'h00);
  endtask

  // Control word stands in for the terminals
  task automatic s_remote;
    tick();
    hw_release_i <= 1'b1;
    terminal_inputs_i <= 10'h2C6;
    master.put_word(CTRL_SRC_REMOTE, 16'hFDAB);
    cyc(2);
    chk(command_inputs_o, 10'h1AB);
    chk(input_monitor_o, 10'h1AB);
    chk(drive_state_flags_o[ST_REMOTE], 1'b1);
    chk(hw_source_inputs_o, 10'h2C6);
    master.put_word(CTRL_SRC_REMOTE, 16'h01AA);
    cyc(2);
    chk(command_inputs_o, 10'h1AA);
    chk(input_monitor_o, 10'h000);
    tick();
    hw_release_i <= 1'b0;
    cyc(2);
    chk(command_inputs_o, 10'h000);
    chk(drive_state_flags_o[ST_REMOTE], 1'b0);
    master.put_word(8'h00, 16'h01AB);
    cyc(2);
    chk(command_inputs_o, 10'h2C6);
  endtask

  // Release path and state codes
  task automatic s_run;
    tick();
    switched_on_i <= 1'b1;
    hw_release_i <= 1'b1;
    master.put_word(CTRL_SRC_REMOTE, 16'h0001);
    cyc(3);
    chk(drive_state_flags_o[6:0], CODE_OPREL);
    chk(drive_release_o, 1'b1);
    tick();
    hw_release_i <= 1'b0;
    cyc(3);
    chk(drive_release_o, 1'b0);
    chk(drive_state_flags_o[6:0], CODE_SWON);
  endtask

  // Early acknowledge refused, late one taken
  task automatic s_fault;
    tick();
    fault_i <= 1'b1;
    fault_code_i <= 8'h5A;
    cyc(3);
    chk(drive_state_flags_o[6:0], CODE_ERROR);
    chk(current_error_o, 8'h5A);
    tick();
    fault_i <= 1'b0;
    fault_ack_i <= 1'b1;
    tick();
    fault_ack_i <= 1'b0;
    cyc(2);
    chk(drive_state_flags_o[ST_ERROR], 1'b1);
    cyc(20);
    tick();
    fault_ack_i <= 1'b1;
    tick();
    fault_ack_i <= 1'b0;
    cyc(2);
    chk(drive_state_flags_o[ST_ERROR], 1'b0);
    chk(current_error_o, 8'h5A);
  endtask

  // Main sequence; power-up sign needs the ramp first
  initial begin
    miscompares = 0;
    check_count = 0;
    nrst_i = 1'b0;
    {hw_release_i, switched_on_i, fault_i, fault_ack_i, critical_warning_flag_i, power_fail_zero_i} = '0;
    {current_limit_i, torque_limit_i, overvoltage_ctrl_i, ramp_source_i, fault_code_i, warnings_i} = '0;
    {terminal_inputs_i, min_freq_i, tolerance_i, internal_ref_freq_i, actual_freq_i} = '0;
    repeat (4) tick();
    nrst_i <= 1'b1;
    s_ramp();
    s_flags();
    s_remote();
    s_run();
    s_fault();
    conclude();
  end

  // Hang guard
  initial begin
    #2000000;
    miscompares++;
    conclude();
  end
endmodule
